// File: design/lmd_pkg.sv
// Package: register map, field layout, reset values and timing for loop control
package lmd_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // Register byte offsets on the Wishbone slave
  localparam logic [3:0] OFF_MULT_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_GATE = 4'h8;
  localparam logic [3:0] OFF_CLKSEL = 4'hC;
  // Multiplier control fields
  localparam int unsigned MULT_LSB = 0;
  localparam int unsigned MULT_W = 5;
  localparam logic [4:0] MULT_RESET = 5'h00;
  localparam logic [4:0] MULT_BYPASS = 5'h00;
  // Status fields
  localparam int unsigned LOCK_BIT = 0;
  localparam int unsigned PDOWN_BIT = 2;
  localparam int unsigned RATIO_LSB = 7;
  localparam int unsigned RATIO_W = 2;
  localparam logic [15:0] STATUS_RESET = 16'h0001;
  localparam logic [1:0] RATIO_RESET = 2'h0;
  // Output ratio select encodings
  localparam logic [1:0] RATIO_DIV8 = 2'h0;
  localparam logic [1:0] RATIO_DIV4 = 2'h1;
  localparam logic [1:0] RATIO_DIV2 = 2'h2;
  localparam logic [1:0] RATIO_DIV1 = 2'h3;
  // Core clock source codes reported on clock_source_o
  localparam logic [1:0] SRC_REF = 2'h0;
  localparam logic [1:0] SRC_REF_HALF = 2'h1;
  localparam logic [1:0] SRC_LOOP = 2'h2;
  localparam logic [1:0] SRC_OFF = 2'h3;
  // Lock interval in reference clock cycles
  localparam int unsigned LOCK_REF_CYCLES = 4096;
  localparam int unsigned LOCK_CNT_W = 16;
  typedef enum logic [1:0] {
    LMD_LOCKED = 2'b00,
    LMD_RELOCK = 2'b01
  } lmd_state_t;
endpackage

// File: design/lmd_lock_if.sv
// Interface: request and completion between register file and lock sequencer
`timescale 1ns/1ps
interface lmd_lock_if;
  logic start;
  logic done;
  logic busy;
  modport ctrl (output start, input done, input busy);
  modport seq (input start, output done, output busy);
endinterface

// File: design/lmd_lock_seq.sv
// Lock sequencer: counts reference cycles after each multiplier write
`timescale 1ns/1ps
module lmd_lock_seq #(
  parameter int unsigned LOCK_CYCLES = lmd_pkg::LOCK_REF_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ref_tick_i,
  lmd_lock_if.seq lk
);
  import lmd_pkg::*;
  localparam logic [LOCK_CNT_W-1:0] LAST = LOCK_CNT_W'(LOCK_CYCLES - 1);
  lmd_state_t state;
  logic [LOCK_CNT_W-1:0] cnt;

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= LMD_LOCKED;
      cnt <= '0;
    end else if (lk.start) begin
      // A new write restarts the whole interval
      state <= LMD_RELOCK; // R16
      cnt <= '0;
    end else begin
      unique case (state)
        LMD_LOCKED: begin
          cnt <= '0;
        end
        LMD_RELOCK: begin
          if (ref_tick_i) begin
            if (cnt == LAST) begin
              state <= LMD_LOCKED;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
        end
        default: begin
          state <= LMD_LOCKED;
        end
      endcase
    end
  end

  assign lk.busy = (state == LMD_RELOCK);
  assign lk.done = (state == LMD_RELOCK) && ref_tick_i && (cnt == LAST) && !lk.start;
endmodule

// File: design/lmd_top.sv
// Top: Wishbone register file and clock selection for the multiplier loop
// Functional notes
// R1: Multiplier field is bits 4:0, resets zero, bits 15:5 read zero.
// R2: Zero multiplier bypasses the loop; reference/8 by default.
// R3: Non-zero value n gives reference times n+1 before the divider.
// R4: Ratio select in status 8:7; 01 is /4, 10 is /2, 11 is /1.
// R5: Ratio select 00 divides by 8.
// R6: Software keeps ratio 0 before multiplier writes, raises it after lock.
// R7: Software uses divide by 1 only when bypassed or powered down.
// R8: Registers reset only by external pin or watchdog reset.
// R9: Writes to both registers land only while the gate is open.
// R10: Status bit 2 powers the loop down while set.
// R11: Power-down only in bypass; no non-zero multiplier while down.
// R12: Loop stays powered down through standby and halt wakeup.
// R13: Multiplier write clears lock flag; core runs at reference/2.
// R14: Lock completion sets flag and switches to the new frequency.
// R15: Software avoids multiplier writes while ratio is 01 or 10.
// R16: Lock interval is a configurable count of reference cycles.
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
module lmd_top #(
  parameter int unsigned LOCK_CYCLES = lmd_pkg::LOCK_REF_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic external_reset_pin_i,
  input wire logic watchdog_reset_i,
  input wire logic debug_reset_i,
  input wire logic missing_clock_reset_i,
  input wire logic reference_tick_i,
  input wire logic protected_write_gate_i,
  input wire logic low_power_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  output logic [lmd_pkg::MULT_W-1:0] loop_multiplier_o,
  output logic [5:0] loop_ratio_o,
  output logic [3:0] output_divisor_o,
  output logic [1:0] clock_source_o,
  output logic loop_power_down_o,
  output logic lock_done_flag_o
);
  import lmd_pkg::*;

  lmd_lock_if lk ();
  logic [MULT_W-1:0] multiplier_control_reg;
  logic [RATIO_W-1:0] output_ratio_select;
  logic loop_power_down;
  logic lock_done_flag;
  logic reg_reset;
  logic req;
  logic hit_mult;
  logic hit_status;
  logic hit_known;
  logic wr_lo;
  logic mult_wr;
  logic status_wr;
  logic [15:0] status_word;
  logic [31:0] next_dat;
  logic [1:0] next_src;
  logic [3:0] next_div;

  // --------------------------------------------------------------
  // Reset scope and bus decode
  // --------------------------------------------------------------
  // Debugger and missing-clock resets are deliberately not ORed in here
  assign reg_reset = rst_i || external_reset_pin_i || watchdog_reset_i; // R8
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign hit_mult = (adr_i == OFF_MULT_CTRL);
  assign hit_status = (adr_i == OFF_STATUS);
  assign hit_known = hit_mult || hit_status || (adr_i == OFF_GATE) || (adr_i == OFF_CLKSEL);
  assign wr_lo = we_i && (sel_i[0] || sel_i[1]);
  // Closed gate: write is acked but dropped, as protected registers do
  assign mult_wr = req && hit_mult && wr_lo && sel_i[0] && protected_write_gate_i; // R9
  assign status_wr = req && hit_status && wr_lo && protected_write_gate_i; // R9

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      ack_o <= req && hit_known;
      err_o <= req && !hit_known;
    end
  end

  // --------------------------------------------------------------
  // Multiplier control register
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reg_reset) begin
      multiplier_control_reg <= MULT_RESET; // R1
    end else if (mult_wr) begin
      multiplier_control_reg <= dat_i[MULT_LSB +: MULT_W]; // R1
    end
  end

  // --------------------------------------------------------------
  // Status register
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reg_reset) begin
      output_ratio_select <= RATIO_RESET;
    end else if (status_wr) begin
      // Bit 7 sits in lane 0, bit 8 in lane 1
      if (sel_i[0]) begin
        output_ratio_select[0] <= dat_i[RATIO_LSB]; // R4
      end
      if (sel_i[1]) begin
        output_ratio_select[1] <= dat_i[RATIO_LSB + 1]; // R4
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reg_reset) begin
      loop_power_down <= STATUS_RESET[PDOWN_BIT];
    end else if (status_wr && sel_i[0]) begin
      loop_power_down <= dat_i[PDOWN_BIT]; // R10
    end
  end

  // Low-power entry and exit never touch the power-down bit
  assign loop_power_down_o = loop_power_down; // R12

  assign lk.start = mult_wr; // R13

  always_ff @(posedge clk_i) begin
    if (reg_reset) begin
      lock_done_flag <= STATUS_RESET[LOCK_BIT]; // R14
    end else if (mult_wr) begin
      lock_done_flag <= 1'b0; // R13
    end else if (lk.done) begin
      lock_done_flag <= 1'b1; // R14
    end
  end

  // Sequencer follows the register reset scope so a lock survives
  // debugger resets alongside the flag
  lmd_lock_seq #(
    .LOCK_CYCLES(LOCK_CYCLES)
  ) u_seq (
    .clk_i(clk_i),
    .rst_i(reg_reset),
    .ref_tick_i(reference_tick_i),
    .lk(lk.seq)
  );

  // --------------------------------------------------------------
  // Core clock selection
  // --------------------------------------------------------------
  always_comb begin
    next_src = SRC_LOOP;
    if (!lock_done_flag || lk.busy) begin
      next_src = SRC_REF_HALF; // R13
    end else if (multiplier_control_reg == MULT_BYPASS) begin
      next_src = SRC_REF; // R2
    end else if (loop_power_down) begin
      // Misuse: non-zero multiplier with loop off leaves no loop clock
      next_src = SRC_OFF; // R10
    end else if (low_power_i) begin
      next_src = SRC_OFF;
    end
  end

  always_comb begin
    unique case (output_ratio_select)
      RATIO_DIV8: next_div = 4'h8; // R5
      RATIO_DIV4: next_div = 4'h4; // R4
      RATIO_DIV2: next_div = 4'h2; // R4
      RATIO_DIV1: next_div = 4'h1; // R4
    endcase
    // Relock period runs at reference/2 whatever the select says
    if (!lock_done_flag) begin
      next_div = 4'h1; // R13
    end
  end

  always_ff @(posedge clk_i) begin
    if (reg_reset) begin
      clock_source_o <= SRC_REF;
      output_divisor_o <= 4'h8;
      loop_ratio_o <= 6'h01;
    end else begin
      clock_source_o <= next_src; // R14
      output_divisor_o <= next_div;
      if (multiplier_control_reg == MULT_BYPASS) begin
        loop_ratio_o <= 6'h01; // R2
      end else begin
        loop_ratio_o <= {1'b0, multiplier_control_reg} + 6'h01; // R3
      end
    end
  end

  assign loop_multiplier_o = multiplier_control_reg;
  assign lock_done_flag_o = lock_done_flag;

  // --------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------
  always_comb begin
    status_word = 16'h0000;
    status_word[RATIO_LSB +: RATIO_W] = output_ratio_select;
    status_word[PDOWN_BIT] = loop_power_down;
    status_word[LOCK_BIT] = lock_done_flag;
    next_dat = 32'h0000_0000;
    if (hit_mult) begin
      next_dat[MULT_LSB +: MULT_W] = multiplier_control_reg; // R1
    end else if (hit_status) begin
      next_dat[15:0] = status_word;
    end else if (adr_i == OFF_GATE) begin
      next_dat[0] = protected_write_gate_i;
    end else if (adr_i == OFF_CLKSEL) begin
      next_dat[1:0] = clock_source_o;
      next_dat[11:8] = output_divisor_o;
      next_dat[21:16] = loop_ratio_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req && !we_i) begin
      dat_o <= next_dat;
    end
  end
endmodule

// File: bench/lmd_top_asserts.sv
// Checker: bus answer, relock, ratio and reset scope at the top ports
`timescale 1ns/1ps
module lmd_top_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic external_reset_pin_i,
  input wire logic watchdog_reset_i,
  input wire logic debug_reset_i,
  input wire logic protected_write_gate_i,
  input wire logic low_power_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic [lmd_pkg::MULT_W-1:0] loop_multiplier_o,
  input wire logic [5:0] loop_ratio_o,
  input wire logic [3:0] output_divisor_o,
  input wire logic [1:0] clock_source_o,
  input wire logic lock_done_flag_o
);
  import lmd_pkg::*;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Register resets from other sources would mask the checks below
  wire quiet = !external_reset_pin_i && !watchdog_reset_i;
  sequence s_mult_wr;
    cyc_i && stb_i && we_i && !ack_o && !err_o && adr_i == OFF_MULT_CTRL;
  endsequence
  sequence s_relock;
    clock_source_o == SRC_REF_HALF && output_divisor_o == 4'h1;
  endsequence
  a_bus_answer: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
    else $error("bus request not answered");
  a_mult_rdzero: assert property (ack_o && !we_i && adr_i == OFF_MULT_CTRL |->
    dat_o[31:5] == 27'h0) else $error("reserved bits not zero");
  a_gate_closed: assert property (s_mult_wr ##0 (!protected_write_gate_i && quiet) |=>
    $stable(loop_multiplier_o)) else $error("write landed with gate closed");
  a_write_unlocks: assert property (s_mult_wr ##0 (protected_write_gate_i && sel_i[0] && quiet)
    |=> !lock_done_flag_o ##1 s_relock) else $error("write did not start relock");
  a_relock_hold: assert property (!lock_done_flag_o && $past(lock_done_flag_o) == 1'b0
    |-> s_relock) else $error("relock not on half reference");
  a_ratio_map: assert property ($stable(loop_multiplier_o) |-> loop_ratio_o ==
    (loop_multiplier_o == MULT_BYPASS ? 6'h01 : {1'b0, loop_multiplier_o} + 6'h01))
    else $error("loop ratio wrong");
  a_debug_keeps: assert property (debug_reset_i && quiet && !(cyc_i && stb_i) |=>
    $stable(loop_multiplier_o)) else $error("debug reset changed register");
  a_ext_defaults: assert property (external_reset_pin_i |=>
    loop_multiplier_o == MULT_RESET && lock_done_flag_o) else $error("pin reset missed");
  a_done_source: assert property ($rose(lock_done_flag_o) && quiet && !low_power_i &&
    loop_multiplier_o != MULT_BYPASS |=> clock_source_o == SRC_LOOP)
    else $error("no switch to loop clock");
endmodule

bind lmd_top lmd_top_asserts chk_i (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .external_reset_pin_i(external_reset_pin_i),
  .watchdog_reset_i(watchdog_reset_i),
  .debug_reset_i(debug_reset_i),
  .protected_write_gate_i(protected_write_gate_i),
  .low_power_i(low_power_i),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .we_i(we_i),
  .adr_i(adr_i),
  .sel_i(sel_i),
  .dat_o(dat_o),
  .ack_o(ack_o),
  .err_o(err_o),
  .loop_multiplier_o(loop_multiplier_o),
  .loop_ratio_o(loop_ratio_o),
  .output_divisor_o(output_divisor_o),
  .clock_source_o(clock_source_o),
  .lock_done_flag_o(lock_done_flag_o)
);

// File: bench/tb.sv
// Testbench: register access, relock, ratio, power-down and reset scope
`timescale 1ns/1ps
module tb;
  import lmd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i, external_reset_pin_i, watchdog_reset_i, debug_reset_i, missing_clock_reset_i;
  logic reference_tick_i, protected_write_gate_i, low_power_i, cyc_i, stb_i, we_i;
  logic [3:0] adr_i, sel_i, output_divisor_o;
  logic [31:0] dat_i, dat_o, rd;
  logic ack_o, err_o, loop_power_down_o, lock_done_flag_o, seen_err;
  logic [4:0] loop_multiplier_o;
  logic [5:0] loop_ratio_o;
  logic [1:0] clock_source_o;
  int bad_count, comparisons;
  // Short lock count keeps the run brief
  lmd_top #(
    .LOCK_CYCLES(4)
  ) dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .external_reset_pin_i(external_reset_pin_i),
    .watchdog_reset_i(watchdog_reset_i),
    .debug_reset_i(debug_reset_i),
    .missing_clock_reset_i(missing_clock_reset_i),
    .reference_tick_i(reference_tick_i),
    .protected_write_gate_i(protected_write_gate_i),
    .low_power_i(low_power_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .err_o(err_o),
    .loop_multiplier_o(loop_multiplier_o),
    .loop_ratio_o(loop_ratio_o),
    .output_divisor_o(output_divisor_o),
    .clock_source_o(clock_source_o),
    .loop_power_down_o(loop_power_down_o),
    .lock_done_flag_o(lock_done_flag_o)
  );
  always #2 clk_i = ~clk_i;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
    rd = dat_o;
    seen_err = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i);
      reference_tick_i <= 1'b1;
      @(posedge clk_i);
      reference_tick_i <= 1'b0;
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {external_reset_pin_i, watchdog_reset_i, debug_reset_i, missing_clock_reset_i} = 4'h0;
    {reference_tick_i, protected_write_gate_i, low_power_i, cyc_i, stb_i, we_i} = 6'h00;
    {adr_i, sel_i, dat_i} = {4'h0, 4'hF, 32'h0};
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(OFF_MULT_CTRL, 32'h0, "mult reset");
    rdchk(OFF_STATUS, 32'h1, "status reset");
    rdchk(OFF_CLKSEL, 32'h0001_0800, "bypass div8");
    bus(1'b1, OFF_MULT_CTRL, 32'h1F);
    rdchk(OFF_MULT_CTRL, 32'h0, "gated write");
    $display("test reset and gate done");
    protected_write_gate_i <= 1'b1;
    bus(1'b1, OFF_MULT_CTRL, 32'hFFFF);
    rdchk(OFF_MULT_CTRL, 32'h1F, "mult field");
    rdchk(OFF_STATUS, 32'h0, "lock cleared");
    rdchk(OFF_CLKSEL, 32'h0020_0101, "relock half ref");
    chk("source pin", {30'h0, SRC_REF_HALF}, {30'h0, clock_source_o});
    ticks(4);
    rdchk(OFF_STATUS, 32'h1, "lock set");
    rdchk(OFF_CLKSEL, 32'h0020_0802, "loop x32 div8");
    chk("mult pin", 32'h1F, {27'h0, loop_multiplier_o});
    chk("ratio pin", 32'h20, {26'h0, loop_ratio_o});
    chk("divisor pin", 32'h8, {28'h0, output_divisor_o});
    chk("loop pin", {30'h0, SRC_LOOP}, {30'h0, clock_source_o});
    chk("flag pin", 32'h1, {31'h0, lock_done_flag_o});
    low_power_i <= 1'b1;
    rdchk(OFF_CLKSEL, 32'h0020_0803, "standby off");
    low_power_i <= 1'b0;
    $display("test relock done");
    bus(1'b1, OFF_MULT_CTRL, 32'h0);
    ticks(4);
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, OFF_STATUS, 32'(r) << 7);
      rdchk(OFF_STATUS, (32'(r) << 7) | 32'h1, "ratio field");
      rdchk(OFF_CLKSEL, 32'h0001_0000 | ((32'h8 >> r) << 8), "divisor");
    end
    $display("test ratio done");
    bus(1'b1, OFF_STATUS, 32'h4);
    low_power_i <= 1'b1;
    rdchk(OFF_STATUS, 32'h5, "power down");
    low_power_i <= 1'b0;
    chk("pdown pin", 32'h1, {31'h0, loop_power_down_o});
    debug_reset_i <= 1'b1;
    missing_clock_reset_i <= 1'b1;
    @(posedge clk_i);
    debug_reset_i <= 1'b0;
    missing_clock_reset_i <= 1'b0;
    rdchk(OFF_STATUS, 32'h5, "debug keeps");
    external_reset_pin_i <= 1'b1;
    @(posedge clk_i);
    external_reset_pin_i <= 1'b0;
    rdchk(OFF_STATUS, 32'h1, "pin reset");
    bus(1'b1, OFF_STATUS, 32'h4);
    watchdog_reset_i <= 1'b1;
    @(posedge clk_i);
    watchdog_reset_i <= 1'b0;
    rdchk(OFF_STATUS, 32'h1, "watchdog reset");
    protected_write_gate_i <= 1'b0;
    bus(1'b1, OFF_STATUS, 32'h184);
    rdchk(OFF_STATUS, 32'h1, "gated status");
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, seen_err});
    $display("test power and resets done");
    print_verdict;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    bad_count++;
    $display("watchdog expired");
    print_verdict;
  end
endmodule
